// File: core/dport_consts.svh
// constants for the indirect ram data port: offsets, fields, resets
// assumes inclusion from the data port module and the bench only
`ifndef DPORT_CONSTS_SVH
`define DPORT_CONSTS_SVH
`define OFS_TARGET_SELECT 8'h24
`define OFS_COMMAND 8'h28
`define OFS_WORD_ADDRESS 8'h2c
`define OFS_DATA_WORD 8'h30
`define READY_BIT 31
`define TARGET_W 4
`define ADDR_W 14
`define RST_TARGET 4'h0
`define RST_COMMAND 1'b0
`define RST_ADDRESS 14'h0000
`define RST_DATA 32'h0000_0000
// ram answer timeout in cycles: 1 us at 100 MHz
`define RAM_TIMEOUT_NS 1000
`define CLK_PERIOD_NS 10
`define RAM_TIMEOUT_CYC (`RAM_TIMEOUT_NS / `CLK_PERIOD_NS)
`endif

// File: core/dport_pkg.sv
// types for the indirect ram data port
// assumes dport_consts.svh is on the include path
`default_nettype none
package dport_pkg;
   typedef enum logic [3:0] {
      TGT_RX_BUF = 4'h0,
      TGT_VLAN_HASH = 4'h1,
      TGT_SEG_HDR = 4'h2,
      TGT_RX_FIFO = 4'h3,
      TGT_TX_FIFO = 4'h4,
      TGT_DESCR = 4'h5,
      TGT_TX_BUF = 4'h7
   } target_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_REQ = 3'b010,
      ST_WAIT = 3'b100
   } state_t;
   // request toward the internal rams
   typedef struct packed {
      logic [6:0] sel;
      logic wr;
      logic [13:0] addr;
      logic [31:0] wdata;
   } ram_req_t;
endpackage
`default_nettype wire

// File: core/dport_regs.sv
// Operation
// - ready flag bit 31, 1 idle, resets 1
// - read sets ready at the same edge that stores the data
// - four-bit target code selects ram, resets 0
// - command write while ready with a mapped target starts one access
// - 14-bit word address used, upper reserved
// - data register holds write and read word
//
// apb slave holding the data port registers and the ram access sequencer
// assumes rams answer a one-cycle request with a one-cycle ack
//
// The implementer's own choice: the APB register port.
`include "dport_consts.svh"
`default_nettype none
module dport_regs #(
   parameter int unsigned TIMEOUT_CYC = `RAM_TIMEOUT_CYC
) (
   // clock and reset
   input wire logic I_CLK,
   input wire logic I_RESETN,
   // apb slave
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [7:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   output logic [31:0] O_PRDATA,
   // ram side
   output dport_pkg::ram_req_t O_RAM_REQ,
   output logic O_RAM_STROBE,
   input wire logic I_RAM_ACK,
   input wire logic [31:0] I_RAM_RDATA
);
   // =====================================================
   // reset release
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // =====================================================
   // decode
   function automatic logic is_mapped(input logic [7:0] a);
      return a == `OFS_TARGET_SELECT || a == `OFS_COMMAND ||
         a == `OFS_WORD_ADDRESS || a == `OFS_DATA_WORD;
   endfunction

   function automatic logic [6:0] target_onehot(input logic [3:0] t);
      logic [6:0] s;
      s = 7'h00;
      case (t)
         dport_pkg::TGT_RX_BUF: s = 7'h01;
         dport_pkg::TGT_VLAN_HASH: s = 7'h02;
         dport_pkg::TGT_SEG_HDR: s = 7'h04;
         dport_pkg::TGT_RX_FIFO: s = 7'h08;
         dport_pkg::TGT_TX_FIFO: s = 7'h10;
         dport_pkg::TGT_DESCR: s = 7'h20;
         dport_pkg::TGT_TX_BUF: s = 7'h40;
         default: s = 7'h00;
      endcase
      return s;
   endfunction

   // =====================================================
   // registers and sequencer
   logic [3:0] target;
   logic command;
   logic [13:0] address;
   logic [31:0] data;
   logic ready;
   dport_pkg::state_t state;
   logic [15:0] wait_cnt;
   logic pready;
   logic pslverr;
   logic [31:0] prdata;
   dport_pkg::ram_req_t ram_req;
   logic ram_strobe;

   logic [3:0] next_target;
   logic next_command;
   logic [13:0] next_address;
   logic [31:0] next_data;
   logic next_ready;
   dport_pkg::state_t next_state;
   logic [15:0] next_wait_cnt;
   logic next_pready;
   logic next_pslverr;
   logic [31:0] next_prdata;
   dport_pkg::ram_req_t next_ram_req;
   logic next_ram_strobe;

   logic setup;
   logic access;
   logic wr_cmd;
   assign setup = I_PSEL && !I_PENABLE && !pready;
   // writes land only at the edge that completes the transfer
   assign access = I_PSEL && I_PENABLE && pready;
   assign wr_cmd = access && I_PWRITE && I_PADDR == `OFS_COMMAND;

   always_comb begin
      next_target = target;
      next_command = command;
      next_address = address;
      next_data = data;
      next_ready = ready;
      next_state = state;
      next_wait_cnt = wait_cnt;
      next_pready = 1'b0;
      next_pslverr = 1'b0;
      next_prdata = prdata;
      next_ram_req = ram_req;
      next_ram_strobe = 1'b0;
      // answer in the access cycle; write lands at the completing edge
      if (setup) begin
         next_pready = 1'b1;
         next_pslverr = !is_mapped(I_PADDR);
         next_prdata = 32'h0000_0000;
         if (!I_PWRITE) begin
            case (I_PADDR)
               `OFS_TARGET_SELECT:
                  next_prdata = {ready, 27'h0, target};
               `OFS_COMMAND: next_prdata = {31'h0, command};
               `OFS_WORD_ADDRESS: next_prdata = {18'h0, address};
               `OFS_DATA_WORD: next_prdata = data;
               default: next_prdata = 32'h0000_0000;
            endcase
         end
      end
      // writes while busy still store; software must not do so
      if (access && I_PWRITE) begin
         case (I_PADDR)
            `OFS_TARGET_SELECT: next_target = I_PWDATA[3:0];
            `OFS_COMMAND: next_command = I_PWDATA[0];
            `OFS_WORD_ADDRESS: next_address = I_PWDATA[13:0];
            `OFS_DATA_WORD: next_data = I_PWDATA;
            default: next_address = address;
         endcase
      end
      case (state)
         dport_pkg::ST_IDLE: begin
            if (wr_cmd && ready) begin
               if (target_onehot(target) == 7'h00) begin
                  next_ready = 1'b1;
               end else begin
                  next_ready = 1'b0;
                  next_state = dport_pkg::ST_REQ;
               end
            end
         end
         dport_pkg::ST_REQ: begin
            next_ram_req.sel = target_onehot(target);
            next_ram_req.wr = command;
            next_ram_req.addr = address;
            next_ram_req.wdata = data;
            next_ram_strobe = 1'b1;
            next_wait_cnt = 16'h0000;
            next_state = dport_pkg::ST_WAIT;
         end
         dport_pkg::ST_WAIT: begin
            next_wait_cnt = wait_cnt + 16'h0001;
            // timeout keeps a dead ram from hanging the port forever
            if (I_RAM_ACK || wait_cnt == 16'(TIMEOUT_CYC)) begin
               if (I_RAM_ACK && !ram_req.wr) begin
                  next_data = I_RAM_RDATA;
               end
               next_ready = 1'b1;
               next_state = dport_pkg::ST_IDLE;
            end
         end
         default: next_state = dport_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         target <= `RST_TARGET;
         command <= `RST_COMMAND;
         address <= `RST_ADDRESS;
         data <= `RST_DATA;
         ready <= 1'b1;
         state <= dport_pkg::ST_IDLE;
         wait_cnt <= 16'h0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         ram_req <= '0;
         ram_strobe <= 1'b0;
      end else begin
         target <= next_target;
         command <= next_command;
         address <= next_address;
         data <= next_data;
         ready <= next_ready;
         state <= next_state;
         wait_cnt <= next_wait_cnt;
         pready <= next_pready;
         pslverr <= next_pslverr;
         prdata <= next_prdata;
         ram_req <= next_ram_req;
         ram_strobe <= next_ram_strobe;
      end
   end

   assign O_PREADY = pready;
   assign O_PSLVERR = pslverr;
   assign O_PRDATA = prdata;
   assign O_RAM_REQ = ram_req;
   assign O_RAM_STROBE = ram_strobe;

   // =====================================================
   // assertions
   a_ready_reset: assert property (@(posedge I_CLK)
      $rose(rst_n) |-> ready)
      else $error("ready not set after reset");
   a_busy_on_cmd: assert property (@(posedge I_CLK) disable iff (!rst_n)
      (wr_cmd && ready && state == dport_pkg::ST_IDLE &&
      target_onehot(target) != 7'h00) |=> !ready ##1 ram_strobe)
      else $error("command did not start an access");
   a_read_data: assert property (@(posedge I_CLK) disable iff (!rst_n)
      (state == dport_pkg::ST_WAIT && I_RAM_ACK && !ram_req.wr) |=>
      (ready && data == $past(I_RAM_RDATA)))
      else $error("read data not stored with ready");
   a_reserved_tgt: assert property (@(posedge I_CLK) disable iff (!rst_n)
      (wr_cmd && ready && target_onehot(target) == 7'h00) |=>
      (ready && !ram_strobe))
      else $error("reserved target started ram access");
   a_ram_addr: assert property (@(posedge I_CLK) disable iff (!rst_n)
      ram_strobe |-> (ram_req.addr == address &&
      ram_req.sel == target_onehot(target)))
      else $error("ram request address mismatch");
   a_write_data: assert property (@(posedge I_CLK) disable iff (!rst_n)
      (ram_strobe && ram_req.wr) |-> ram_req.wdata == data)
      else $error("write word differs from data register");
   a_ready_bit: assert property (@(posedge I_CLK) disable iff (!rst_n)
      (pready && !I_PWRITE && I_PADDR == `OFS_TARGET_SELECT) |->
      O_PRDATA[`READY_BIT] == $past(ready))
      else $error("ready bit read wrong");
   a_target_store: assert property (@(posedge I_CLK) disable iff (!rst_n)
      (access && I_PWRITE && I_PADDR == `OFS_TARGET_SELECT) |=>
      target == $past(I_PWDATA[3:0]))
      else $error("target select not stored");
   c_read: cover property (@(posedge I_CLK)
      ram_strobe && !ram_req.wr ##[1:20] ready);
   c_write: cover property (@(posedge I_CLK) ram_strobe && ram_req.wr);
   c_reserved: cover property (@(posedge I_CLK)
      wr_cmd && target_onehot(target) == 7'h00);
endmodule
`default_nettype wire

// File: tb/indirect_ram_data_port_tb_top.sv
// bench for the data port registers: apb master plus a ram stub
// assumes dport_regs, dport_pkg and dport_consts.svh are compiled first
`include "dport_consts.svh"
`default_nettype none
module indirect_ram_data_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] SEL = `OFS_TARGET_SELECT;
   localparam logic [7:0] CMD = `OFS_COMMAND;
   localparam logic [7:0] ADR = `OFS_WORD_ADDRESS;
   localparam logic [7:0] DAT = `OFS_DATA_WORD;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic pready, pslverr, strobe, err;
   logic [31:0] prdata, rd;
   logic ack = 1'b0;
   logic [31:0] rdata = 32'hffff_ffff;
   dport_pkg::ram_req_t req, seen;
   int strobes = 0, wait_cnt = 0, cycles = 0, n0;
   int fail_count = 0, checked = 0;
   logic [3:0] codes [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7};
   logic [3:0] rsv [3] = '{4'h6, 4'h8, 4'hf};
   logic [6:0] oh;

   always #5 clk = ~clk;

   dport_regs #(.TIMEOUT_CYC(8)) dut (.I_CLK(clk), .I_RESETN(resetn),
      .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
      .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready),
      .O_PSLVERR(pslverr), .O_PRDATA(prdata), .O_RAM_REQ(req),
      .O_RAM_STROBE(strobe), .I_RAM_ACK(ack), .I_RAM_RDATA(rdata));

   // =========================================================
   // ram stub
   // slow answer so the busy window is visible; data toggles off ack
   always @(posedge clk) begin
      ack <= 1'b0;
      rdata <= ~rdata;
      if (strobe === 1'b1) begin
         seen <= req;
         strobes <= strobes + 1;
         wait_cnt <= 3;
      end else if (wait_cnt == 1) begin
         ack <= 1'b1;
         rdata <= {seen.sel, 11'h5a5, seen.addr};
         wait_cnt <= 0;
      end else if (wait_cnt > 1) begin
         wait_cnt <= wait_cnt - 1;
      end
   end

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fail_count++;
         end_of_test();
      end
   end

   // =========================================================
   // tasks
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic poll();
      int n;
      n = 0;
      apb(1'b0, SEL, 32'h0);
      while (rd[31] !== 1'b1 && n < 40) begin
         apb(1'b0, SEL, 32'h0);
         n++;
      end
      chk({31'h0, rd[31]}, 32'h1);
   endtask

   task automatic end_of_test();
      $display("counts: checked=%0d fail_count=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // =========================================================
   // tests
   initial begin
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
      apb(1'b0, SEL, 32'h0);
      chk(rd, 32'h8000_0000);
      apb(1'b0, CMD, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, ADR, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, DAT, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, ADR, 32'hffff_ffff);
      apb(1'b0, ADR, 32'h0);
      chk(rd, 32'h0000_3fff);
      $display("test reset and address mask done");
      apb(1'b1, SEL, 32'h1);
      apb(1'b1, ADR, 32'h1234);
      apb(1'b1, DAT, 32'ha5c3_0f96);
      apb(1'b1, CMD, 32'h1);
      apb(1'b0, SEL, 32'h0);
      chk(rd, 32'h1);
      poll();
      chk({10'h0, seen.sel, seen.wr, seen.addr}, 32'h0001_5234);
      chk(seen.wdata, 32'ha5c3_0f96);
      apb(1'b0, CMD, 32'h0);
      chk(rd, 32'h1);
      $display("test ram write done");
      foreach (codes[i]) begin
         apb(1'b1, SEL, {28'h0, codes[i]});
         apb(1'b1, ADR, {18'h0, 14'h3ff8 + codes[i]});
         apb(1'b1, CMD, 32'h0);
         poll();
         oh = (codes[i] == 4'h7) ? 7'h40 : 7'h01 << codes[i];
         apb(1'b0, DAT, 32'h0);
         chk(rd, {oh, 11'h5a5, 14'h3ff8 + codes[i]});
         chk({31'h0, seen.wr}, 32'h0);
      end
      $display("test ram reads done");
      foreach (rsv[i]) begin
         n0 = strobes;
         apb(1'b1, SEL, {28'h0, rsv[i]});
         apb(1'b1, CMD, 32'h1);
         apb(1'b0, SEL, 32'h0);
         chk(rd, {1'b1, 27'h0, rsv[i]});
         chk(strobes - n0, 32'h0);
      end
      $display("test reserved targets done");
      apb(1'b0, 8'h34, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      $display("test unmapped address done");
      end_of_test();
   end
endmodule
`default_nettype wire
